/* include/tes_map.svh */
`ifndef TES_MAP_SVH
`define TES_MAP_SVH

// Parameter numbers
`define TES_PARAM_EXT_TRIP 16'hD223
`define TES_PARAM_COMMS_TRIP 16'hD224
`define TES_PARAM_KEYPAD_TRIP 16'hD226
`define TES_PARAM_LOGGING_TRIP 16'hD227
`define TES_PARAM_CONTROL_TRIP 16'hD228
`define TES_PARAM_COVER_TRIP 16'hD22B
`define TES_PARAM_START_TRIP 16'hD22C
`define TES_PARAM_TIMEOUT_MS 16'h3DC0
`define TES_PARAM_TRIP_CAUSE 16'hD2F0

// Reset values
`define TES_RST_EXT_TRIP 8'h00
`define TES_RST_COMMS_TRIP 8'h01
`define TES_RST_KEYPAD_TRIP 8'h01
`define TES_RST_LOGGING_TRIP 8'h01
`define TES_RST_CONTROL_TRIP 8'h01
`define TES_RST_COVER_TRIP 8'h00
`define TES_RST_START_TRIP 8'h01
`define TES_RST_TIMEOUT_MS 16'h03E8

// Trip cause bit positions
`define TES_CAUSE_EXT 0
`define TES_CAUSE_COMMS 1
`define TES_CAUSE_KEYPAD 2
`define TES_CAUSE_LOGGING 3
`define TES_CAUSE_CONTROL 4
`define TES_CAUSE_COVER 5
`define TES_CAUSE_START 6

// Timing
`define TES_CLK_HZ 50000000
`define TES_MS_PER_S 1000
`define TES_CLKS_PER_MS (`TES_CLK_HZ / `TES_MS_PER_S)
`define TES_SYNC_SETTLE 2'h2

`endif

/* include/tes_pkg.sv */
package tes_pkg;

    // Fault and control pins from the outside world
    typedef struct packed {
        logic fault_reset;
        logic remote_start;
        logic cover_open;
        logic control_fail;
        logic logging_fail;
        logic keypad_fail;
        logic ext_trip;
    } tes_pins_t;

    // Parameter access request
    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] parameter_number;
        logic [15:0] wdata;
    } tes_req_t;

    // Parameter access answer
    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] rdata;
    } tes_rsp_t;

    typedef enum logic [0:0] {
        TES_CHK_PENDING,
        TES_CHK_DONE
    } tes_chk_t;

endpackage

/* rtl/tes_trip_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tes_map.svh"

// Functional notes
// - Armed external trip follows assigned input
// - Disarmed external trip input is ignored
// - Armed comms trip on access timeout
// - Disarmed comms trip never fires
// - Keypad failure trips only when armed
// - Logging failure trips only when armed
// - Control board failure trips only when armed
// - Armed cover open trips in any state
// - Disarmed cover open keeps normal operation
// - Armed remote start active at reset trips
// - Disarmed remote start may begin start
// - Enables are 8-bit, read/write, any value but 1 disarms
module tes_trip_supervisor
    import tes_pkg::*;
#(
    parameter int CLKS_PER_MS = `TES_CLKS_PER_MS
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire tes_pins_t pins,
    input wire tes_req_t param_req,
    output tes_rsp_t param_rsp,
    output logic trip,
    output logic [6:0] trip_cause,
    output logic start_request
);

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    tes_pins_t sync1_q;
    tes_pins_t sync2_q;
    tes_pins_t fr_prev_q;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            fr_prev_q <= '0;
        end
        else
        begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            fr_prev_q <= sync2_q;
        end
    end

    logic reset_rise;
    assign reset_rise = sync2_q.fault_reset & ~fr_prev_q.fault_reset;

    // ********************************************************
    // Parameter registers
    // ********************************************************
    logic [7:0] ext_en_q, ext_en_d;
    logic [7:0] comms_en_q, comms_en_d;
    logic [7:0] keypad_en_q, keypad_en_d;
    logic [7:0] logging_en_q, logging_en_d;
    logic [7:0] control_en_q, control_en_d;
    logic [7:0] cover_en_q, cover_en_d;
    logic [7:0] start_en_q, start_en_d;
    logic [15:0] timeout_ms_q, timeout_ms_d;
    tes_rsp_t rsp_q, rsp_d;
    logic [6:0] cause_q, cause_d;

    function automatic logic armed(input logic [7:0] en);
        armed = (en == 8'h01);
    endfunction

    always_comb
    begin
        ext_en_d = ext_en_q;
        comms_en_d = comms_en_q;
        keypad_en_d = keypad_en_q;
        logging_en_d = logging_en_q;
        control_en_d = control_en_q;
        cover_en_d = cover_en_q;
        start_en_d = start_en_q;
        timeout_ms_d = timeout_ms_q;
        rsp_d = '0;
        if (param_req.req)
        begin
            rsp_d.ack = 1'b1;
            if (param_req.parameter_number == `TES_PARAM_EXT_TRIP)
            begin
                rsp_d.rdata = {8'h00, ext_en_q};
                if (param_req.we)
                    ext_en_d = param_req.wdata[7:0];
            end
            else if (param_req.parameter_number == `TES_PARAM_COMMS_TRIP)
            begin
                rsp_d.rdata = {8'h00, comms_en_q};
                if (param_req.we)
                    comms_en_d = param_req.wdata[7:0];
            end
            else if (param_req.parameter_number == `TES_PARAM_KEYPAD_TRIP)
            begin
                rsp_d.rdata = {8'h00, keypad_en_q};
                if (param_req.we)
                    keypad_en_d = param_req.wdata[7:0];
            end
            else if (param_req.parameter_number == `TES_PARAM_LOGGING_TRIP)
            begin
                rsp_d.rdata = {8'h00, logging_en_q};
                if (param_req.we)
                    logging_en_d = param_req.wdata[7:0];
            end
            else if (param_req.parameter_number == `TES_PARAM_CONTROL_TRIP)
            begin
                rsp_d.rdata = {8'h00, control_en_q};
                if (param_req.we)
                    control_en_d = param_req.wdata[7:0];
            end
            else if (param_req.parameter_number == `TES_PARAM_COVER_TRIP)
            begin
                rsp_d.rdata = {8'h00, cover_en_q};
                if (param_req.we)
                    cover_en_d = param_req.wdata[7:0];
            end
            else if (param_req.parameter_number == `TES_PARAM_START_TRIP)
            begin
                rsp_d.rdata = {8'h00, start_en_q};
                if (param_req.we)
                    start_en_d = param_req.wdata[7:0];
            end
            else if (param_req.parameter_number == `TES_PARAM_TIMEOUT_MS)
            begin
                rsp_d.rdata = timeout_ms_q;
                if (param_req.we)
                    timeout_ms_d = param_req.wdata;
            end
            else if (param_req.parameter_number == `TES_PARAM_TRIP_CAUSE)
            begin
                rsp_d.rdata = {9'h000, cause_q};
                rsp_d.err = param_req.we;
            end
            else
            begin
                rsp_d.err = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            ext_en_q <= `TES_RST_EXT_TRIP;
            comms_en_q <= `TES_RST_COMMS_TRIP;
            keypad_en_q <= `TES_RST_KEYPAD_TRIP;
            logging_en_q <= `TES_RST_LOGGING_TRIP;
            control_en_q <= `TES_RST_CONTROL_TRIP;
            cover_en_q <= `TES_RST_COVER_TRIP;
            start_en_q <= `TES_RST_START_TRIP;
            timeout_ms_q <= `TES_RST_TIMEOUT_MS;
            rsp_q <= '0;
        end
        else
        begin
            ext_en_q <= ext_en_d;
            comms_en_q <= comms_en_d;
            keypad_en_q <= keypad_en_d;
            logging_en_q <= logging_en_d;
            control_en_q <= control_en_d;
            cover_en_q <= cover_en_d;
            start_en_q <= start_en_d;
            timeout_ms_q <= timeout_ms_d;
            rsp_q <= rsp_d;
        end
    end

    // ********************************************************
    // Communications inactivity timer
    // ********************************************************
    logic [31:0] tick_q, tick_d;
    logic [15:0] idle_ms_q, idle_ms_d;
    logic comms_timeout;

    always_comb
    begin
        tick_d = tick_q;
        idle_ms_d = idle_ms_q;
        if (param_req.req)
        begin
            tick_d = '0;
            idle_ms_d = '0;
        end
        else if (tick_q == 32'(CLKS_PER_MS - 1))
        begin
            tick_d = '0;
            if (idle_ms_q != 16'hFFFF)
                idle_ms_d = idle_ms_q + 16'h0001;
        end
        else
        begin
            tick_d = tick_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            tick_q <= '0;
            idle_ms_q <= '0;
        end
        else
        begin
            tick_q <= tick_d;
            idle_ms_q <= idle_ms_d;
        end
    end

    assign comms_timeout = (timeout_ms_q != 16'h0000) && (idle_ms_q >= timeout_ms_q);

    // ********************************************************
    // Start-up check and trip latch
    // ********************************************************
    tes_chk_t chk_q, chk_d;
    logic [1:0] settle_q, settle_d;
    logic check_now;
    logic [6:0] new_trip;
    logic start_req_q, start_req_d;

    always_comb
    begin
        chk_d = chk_q;
        settle_d = settle_q;
        check_now = 1'b0;
        case (chk_q)
            TES_CHK_PENDING:
            begin
                if (settle_q == `TES_SYNC_SETTLE)
                begin
                    check_now = 1'b1;
                    chk_d = TES_CHK_DONE;
                end
                else
                begin
                    settle_d = settle_q + 2'h1;
                end
            end
            default:
            begin
                check_now = reset_rise;
            end
        endcase
    end

    always_comb
    begin
        new_trip = '0;
        new_trip[`TES_CAUSE_EXT] = armed(ext_en_q) & sync2_q.ext_trip;
        new_trip[`TES_CAUSE_COMMS] = armed(comms_en_q) & comms_timeout;
        new_trip[`TES_CAUSE_KEYPAD] = armed(keypad_en_q) & sync2_q.keypad_fail;
        new_trip[`TES_CAUSE_LOGGING] = armed(logging_en_q) & sync2_q.logging_fail;
        new_trip[`TES_CAUSE_CONTROL] = armed(control_en_q) & sync2_q.control_fail;
        new_trip[`TES_CAUSE_COVER] = armed(cover_en_q) & sync2_q.cover_open;
        new_trip[`TES_CAUSE_START] = armed(start_en_q) & sync2_q.remote_start & check_now;
    end

    always_comb
    begin
        cause_d = (reset_rise ? 7'h00 : cause_q) | new_trip;
        start_req_d = sync2_q.remote_start & (cause_d == 7'h00);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            chk_q <= TES_CHK_PENDING;
            settle_q <= '0;
            cause_q <= '0;
            start_req_q <= 1'b0;
        end
        else
        begin
            chk_q <= chk_d;
            settle_q <= settle_d;
            cause_q <= cause_d;
            start_req_q <= start_req_d;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    logic trip_q;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            trip_q <= 1'b0;
        else
            trip_q <= (cause_d != 7'h00);
    end

    assign param_rsp = rsp_q;
    assign trip = trip_q;
    assign trip_cause = cause_q;
    assign start_request = start_req_q;

endmodule

`default_nettype wire

/* verification/tes_trip_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Trip checker
// ****************
module tes_trip_chk
    import tes_pkg::*;
#(
    parameter int CLKS_PER_MS = 10
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire tes_pins_t pins,
    input wire tes_req_t param_req,
    input wire tes_rsp_t param_rsp,
    input wire logic trip,
    input wire logic [6:0] trip_cause,
    input wire logic start_request
);
    logic [3:0] fr_age_d;
    logic [3:0] fr_age_q;
    // Cycles since fault reset seen
    always_comb
    begin
        fr_age_d = fr_age_q + {3'h0, fr_age_q != 4'hf};
        if (!reset_n)
            fr_age_d = 4'hf;
        else if (pins.fault_reset)
            fr_age_d = 4'h0;
    end
    always_ff @(posedge sys_clk)
    begin
        fr_age_q <= fr_age_d;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_take;
        param_req.req;
    endsequence
    sequence s_answer;
        param_rsp.ack;
    endsequence
    a_ack_follows: assert property (s_take |=> s_answer)
        else $error("no ack after request");
    a_no_stray_ack: assert property (!param_req.req |=> !param_rsp.ack)
        else $error("ack without request");
    a_idle_rsp_zero: assert property (!param_rsp.ack |-> param_rsp.rdata == 16'h0000 && !param_rsp.err)
        else $error("response busy while idle");
    a_trip_follows: assert property ($rose(|trip_cause) |=> trip)
        else $error("trip missing after cause");
    a_cause_holds: assert property (|($past(trip_cause) & ~trip_cause) |-> fr_age_q < 4'h8)
        else $error("cause dropped without reset");
    a_ext_source: assert property ($rose(trip_cause[0]) |-> $past(pins.ext_trip, 2))
        else $error("external cause without input");
    a_keypad_source: assert property ($rose(trip_cause[2]) |-> $past(pins.keypad_fail, 2))
        else $error("keypad cause without input");
    a_cover_source: assert property ($rose(trip_cause[5]) |-> $past(pins.cover_open, 2))
        else $error("cover cause without input");
    a_start_blocked: assert property (trip && $past(trip) |-> !start_request)
        else $error("start passed during trip");
endmodule
bind tes_trip_supervisor tes_trip_chk #(.CLKS_PER_MS(CLKS_PER_MS)) tes_trip_chk_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .pins(pins), .param_req(param_req),
    .param_rsp(param_rsp), .trip(trip), .trip_cause(trip_cause), .start_request(start_request));
`default_nettype wire

/* verification/tes_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bus master model
// ****************
module tes_master_model
    import tes_pkg::*;
(
    input wire logic sys_clk,
    output tes_req_t param_req,
    input wire tes_rsp_t param_rsp
);
    initial param_req = '0;
    task automatic access(input logic we, input logic [15:0] pn, input logic [15:0] wd,
        output logic [15:0] rd, output logic er);
        @(posedge sys_clk);
        param_req <= '{req: 1'b1, we: we, parameter_number: pn, wdata: wd};
        @(posedge sys_clk);
        param_req.req <= 1'b0;
        @(posedge sys_clk);
        rd = param_rsp.rdata;
        er = param_rsp.ack ? param_rsp.err : 1'bx;
        param_req <= '{req: 1'b0, we: ~we, parameter_number: ~pn, wdata: ~wd};
    endtask
endmodule
`default_nettype wire

/* verification/tb_trip_enable_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Trip bench
// ****************
module tb_trip_enable_supervisor;
    import tes_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    tes_pins_t pins = '0;
    tes_req_t param_req;
    tes_rsp_t param_rsp;
    logic trip;
    logic [6:0] trip_cause;
    logic start_request;
    wire logic [15:0] status = {7'h00, start_request, trip, trip_cause};
    int error_cnt = 0;
    int tests_run = 0;
    int seed = 32'hefb2;
    int en[7] = '{0, 1, 1, 1, 1, 0, 1};
    int src[5] = '{0, 2, 3, 4, 5};
    logic [15:0] pn[7] = '{16'hd223, 16'hd224, 16'hd226, 16'hd227, 16'hd228, 16'hd22b, 16'hd22c};
    logic [15:0] rd;
    logic er;
    logic [31:0] v;
    int k;
    always #10 sys_clk = ~sys_clk;
    tes_trip_supervisor #(.CLKS_PER_MS(10)) tes_trip_supervisor_i (.sys_clk(sys_clk),
        .reset_n(reset_n), .pins(pins), .param_req(param_req), .param_rsp(param_rsp),
        .trip(trip), .trip_cause(trip_cause), .start_request(start_request));
    tes_master_model tes_master_model_i (.sys_clk(sys_clk), .param_req(param_req),
        .param_rsp(param_rsp));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        tes_master_model_i.access(1'b1, a, d, rd, er);
        for (int j = 0; j < 7; j++)
            if (pn[j] == a)
                en[j] = int'(d[7:0]);
    endtask
    task automatic rd_chk(input int j);
        tes_master_model_i.access(1'b0, pn[j], 16'h0000, rd, er);
        check(rd, 16'(en[j]));
    endtask
    task automatic clear_trip;
        pins.fault_reset <= 1'b1;
        cyc(2);
        pins.fault_reset <= 1'b0;
        cyc(8);
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        cyc(5000);
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        cyc(6);
        reset_n <= 1'b1;
        cyc(1);
        for (int i = 0; i < 7; i++)
        begin
            tes_master_model_i.access(1'b0, pn[i], 16'h0000, rd, er);
            check(rd, 16'(en[i]));
            check({15'h0000, er}, 16'h0000);
        end
        tes_master_model_i.access(1'b0, 16'hd225, 16'h0000, rd, er);
        check({15'h0000, er}, 16'h0001);
        v = $random(seed);
        wr(pn[0], v[15:0]);
        rd_chk(0);
        check(rd, {8'h00, v[7:0]});
        wr(pn[1], 16'h0000);
        wr(16'h3dc0, 16'h0002);
        for (int a = 0; a < 2; a++)
            foreach (src[i])
            begin
                k = src[i];
                wr(pn[k], 16'(a));
                pins[k == 0 ? 0 : k - 1] <= 1'b1;
                cyc(6);
                check(status, 16'((a << k) | (a << 7)));
                pins[k == 0 ? 0 : k - 1] <= 1'b0;
                wr(pn[k], 16'h0000);
                cyc(6);
                check(status, 16'((a << k) | (a << 7)));
                clear_trip();
                check(status, 16'h0000);
            end
        cyc(60);
        check(status, 16'h0000);
        wr(pn[1], 16'h0001);
        cyc(8);
        check(status, 16'h0000);
        cyc(40);
        check(status, 16'h0082);
        tes_master_model_i.access(1'b0, 16'hd2f0, 16'h0000, rd, er);
        check(rd, 16'h0002);
        tes_master_model_i.access(1'b1, 16'hd2f0, 16'h007f, rd, er);
        check({15'h0000, er}, 16'h0001);
        check(status, 16'h0082);
        wr(pn[1], 16'h0000);
        pins.remote_start <= 1'b1;
        cyc(1);
        clear_trip();
        check(status, 16'h00c0);
        wr(pn[6], 16'h0000);
        clear_trip();
        check(status, 16'h0100);
        for (int i = 0; i < 7; i++)
            rd_chk(i);
        reset_n <= 1'b0;
        cyc(2);
        reset_n <= 1'b1;
        cyc(6);
        check(status, 16'h00c0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
